/* File: src/rxf_params.svh */
`ifndef RXF_PARAMS_SVH
`define RXF_PARAMS_SVH

`define RXF_MODE_MUX 2'h0
`define RXF_MODE_NIB 2'h2
`define RXF_FIFO_DEPTH 8
`define RXF_WORD_BITS 10
`define RXF_HALF_BITS 5
`define RXF_CFG_RST 3'h0
`define RXF_PINS_RST 11'h000

`endif

/* File: src/rxf_pkg.sv */
package rxf_pkg;

  typedef enum logic [1:0] {
    RXF_MUX = 2'b00,
    RXF_RSV1 = 2'b01,
    RXF_NIB = 2'b10,
    RXF_RSV3 = 2'b11
  } rxf_mode_t;

  // one received word set per receive-clock period
  typedef struct packed {
    logic [9:0] g;
    logic [9:0] h;
    logic g_k;
    logic h_k;
    logic e_b9;
    logic f_b4;
    logic f_b9;
  } rxf_word_t;

  typedef struct packed {
    logic [7:0] bus;
    logic b8;
    logic b9;
    logic ef9;
  } rxf_pins_t;

endpackage

/* File: src/rxf_top.sv */

module rxf_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  wire logic do_wr;
  wire logic do_rd;
  wire logic full;
  wire logic empty;

  assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty = (wr_ptr == rd_ptr);
  assign o_ready = !full;
  assign o_valid = !empty;
  assign do_wr = i_valid && !full;
  assign do_rd = i_ready && !empty;
  assign o_data = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge i_clk) begin
    if (do_wr) begin
      mem[wr_ptr[AW-1:0]] <= i_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  // difference cut to pointer width so a wrapped write pointer still reads as a small count
  occupancy_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (AW+1)'(wr_ptr - rd_ptr) <= DEPTH)
    else $error("fifo occupancy beyond depth");
endmodule

`include "rxf_params.svh"

module rxf_top
  import rxf_pkg::*;
#(
  parameter int FIFO_DEPTH = `RXF_FIFO_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [1:0] i_mode,
  input wire logic i_code,
  input wire logic i_word_valid,
  output logic o_word_ready,
  input wire rxf_word_t i_word,
  output logic o_rclk,
  output logic [7:0] o_rx_gh_data_bus,
  output logic o_rx_gh_bit8_kflag_out,
  output logic o_rx_gh_bit9_out,
  output logic o_rx_ef_bit9_out
);
  // each i_clk cycle is one receive-clock slot: phase 0 falling, 1 rising
  logic phase;
  logic [2:0] cfg_s1;
  logic [2:0] cfg_s2;
  logic [2:0] cfg_s3;
  logic [2:0] cfg;
  logic mode_nib;
  logic code_en;
  rxf_word_t hold;
  rxf_pins_t pins;
  wire logic [2:0] next_cfg;
  wire logic [2:0] cfg_diff;
  wire logic head_valid;
  wire logic head_pop;
  wire rxf_word_t head;
  wire rxf_word_t next_hold;
  wire logic next_nib;
  wire logic next_code;
  wire rxf_pins_t next_pins;

  rxf_fifo #(
    .WIDTH($bits(rxf_word_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_valid(i_word_valid),
    .o_ready(o_word_ready),
    .i_data(i_word),
    .o_valid(head_valid),
    .i_ready(head_pop),
    .o_data(head)
  );

  // pins change only once two later stages agree
  assign cfg_diff = cfg_s2 ^ cfg_s3;
  assign next_cfg = (~cfg_diff & cfg_s3) | (cfg_diff & cfg);

  // reserved mode codes fall back to mux behaviour
  assign next_nib = (cfg[2:1] == `RXF_MODE_NIB);
  assign next_code = cfg[0];

  // a word set is taken only at a pair boundary so it never tears
  assign head_pop = phase && head_valid;
  assign next_hold = head_valid ? head : rxf_word_t'('0);

  function automatic logic [4:0] half(input logic [9:0] w, input logic k,
                                      input logic rise, input logic cd);
    logic [4:0] r;
    r = w[4:0];
    if (rise && !cd) begin
      r = w[9:5];
    end else if (rise) begin
      r = {1'b0, k, w[7:5]};
    end
    return r;
  endfunction

  function automatic rxf_pins_t fmt(input rxf_word_t w, input logic rise,
                                    input logic nib, input logic cd);
    rxf_pins_t p;
    logic [9:0] src;
    logic [9:0] gh;
    logic k;
    src = rise ? w.h : w.g;
    k = rise ? w.h_k : w.g_k;
    gh = {half(w.h, w.h_k, rise, cd), half(w.g, w.g_k, rise, cd)};
    if (nib) begin
      p.bus = gh[7:0];
      p.b8 = gh[8];
      p.b9 = gh[9];
      p.ef9 = cd ? 1'b0 : (rise ? w.f_b9 : w.f_b4);
    end else begin
      p.bus = src[7:0];
      p.b8 = cd ? k : src[8];
      p.b9 = cd ? 1'b0 : src[9];
      p.ef9 = cd ? 1'b0 : (rise ? w.f_b9 : w.e_b9);
    end
    return p;
  endfunction

  assign next_pins = phase ? fmt(next_hold, 1'b0, next_nib, next_code)
                           : fmt(hold, 1'b1, mode_nib, code_en);

  // cleared in reset so the agreement test never feeds unknowns into cfg after release
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      cfg_s1 <= `RXF_CFG_RST;
      cfg_s2 <= `RXF_CFG_RST;
      cfg_s3 <= `RXF_CFG_RST;
    end else begin
      cfg_s1 <= {i_mode, i_code};
      cfg_s2 <= cfg_s1;
      cfg_s3 <= cfg_s2;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      cfg <= `RXF_CFG_RST;
      phase <= 1'b0;
      o_rclk <= 1'b0;
    end else begin
      cfg <= next_cfg;
      phase <= ~phase;
      o_rclk <= ~phase;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      hold <= '0;
      mode_nib <= 1'b0;
      code_en <= 1'b0;
    end else if (phase) begin
      hold <= next_hold;
      mode_nib <= next_nib;
      code_en <= next_code;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      pins <= `RXF_PINS_RST;
    end else begin
      pins <= next_pins;
    end
  end

  assign o_rx_gh_data_bus = pins.bus;
  assign o_rx_gh_bit8_kflag_out = pins.b8;
  assign o_rx_gh_bit9_out = pins.b9;
  assign o_rx_ef_bit9_out = pins.ef9;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  wire logic mux_raw = !mode_nib && !code_en;
  wire logic nib_raw = mode_nib && !code_en;

  sequence s_fall_g_low;
    !o_rclk && o_rx_gh_data_bus[4:0] == hold.g[4:0];
  endsequence

  sequence s_rise_g_high;
    o_rclk && o_rx_gh_data_bus[4:0] == hold.g[9:5];
  endsequence

  sequence s_fall_ef_f4;
    !o_rclk && o_rx_ef_bit9_out == hold.f_b4;
  endsequence

  sequence s_rise_ef_f9;
    o_rclk && o_rx_ef_bit9_out == hold.f_b9;
  endsequence

  rclk_toggle_a: assert property ($past(i_rst_b) |-> o_rclk != $past(o_rclk))
    else $error("receive clock did not toggle");

  ef_bit9_mux_a: assert property (mux_raw |->
    o_rx_ef_bit9_out == (o_rclk ? hold.f_b9 : hold.e_b9))
    else $error("ef bit9 wrong in mux raw mode");

  ef_bit9_nib_a: assert property (nib_raw && !o_rclk |->
    s_fall_ef_f4 ##1 s_rise_ef_f9)
    else $error("ef bit9 wrong in nibble raw mode");

  mux_slot_order_a: assert property (!mode_nib && !o_rclk |->
    o_rx_gh_data_bus == hold.g[7:0] ##1 o_rx_gh_data_bus == hold.h[7:0])
    else $error("mux slot order wrong");

  nib_half_order_a: assert property (nib_raw && !o_rclk |->
    s_fall_g_low ##1 s_rise_g_high)
    else $error("nibble half order wrong");

  nib_h_upper_a: assert property (nib_raw |->
    {o_rx_gh_bit9_out, o_rx_gh_bit8_kflag_out, o_rx_gh_data_bus[7:5]}
      == (o_rclk ? hold.h[9:5] : hold.h[4:0]))
    else $error("channel h not on upper bits");

  g_kflag_nib_a: assert property (mode_nib && code_en && o_rclk |->
    o_rx_gh_data_bus[3] == hold.g_k)
    else $error("g k-flag missing on bit 3");

  gh_bit8_mux_a: assert property (mux_raw |->
    o_rx_gh_bit8_kflag_out == (o_rclk ? hold.h[8] : hold.g[8]))
    else $error("gh bit8 wrong in mux raw mode");

  gh_kflag_mux_a: assert property (!mode_nib && code_en |->
    o_rx_gh_bit8_kflag_out == (o_rclk ? hold.h_k : hold.g_k))
    else $error("gh k-flag wrong in mux mode");

  h_bit8_nib_a: assert property (mode_nib && code_en && !o_rclk |->
    o_rx_gh_bit8_kflag_out == hold.h[3]
    ##1 o_rx_gh_bit8_kflag_out == hold.h_k)
    else $error("h bit8 wrong in nibble decoded mode");

  gh_bit9_mux_a: assert property (mux_raw |->
    o_rx_gh_bit9_out == (o_rclk ? hold.h[9] : hold.g[9]))
    else $error("gh bit9 wrong in mux raw mode");

  gh_bit9_nib_a: assert property (nib_raw && !o_rclk |->
    o_rx_gh_bit9_out == hold.h[4] ##1 o_rx_gh_bit9_out == hold.h[9])
    else $error("gh bit9 wrong in nibble raw mode");

  pop_boundary_a: assert property (head_pop |=> !o_rclk && hold == $past(head))
    else $error("word taken off a pair boundary");

  decoded_quiet_a: assert property (code_en |->
    !o_rx_ef_bit9_out && (mode_nib || !o_rx_gh_bit9_out))
    else $error("raw-only pins not quiet in decoded mode");
endmodule

/* File: testbench/rxf_far_end.sv */
module rxf_far_end (
  input wire logic i_rclk,
  input wire logic [7:0] i_bus,
  input wire logic i_b8,
  input wire logic i_b9,
  input wire logic i_ef9,
  output logic [21:0] o_pair,
  output int o_pairs
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [10:0] fall = '0;
  initial o_pairs = 0;
  initial o_pair = '0;
  // sample 2ns into the 8ns slot so the capture never races the launching edge
  always @(i_rclk) begin
    #2;
    if (!i_rclk) begin
      fall = {i_ef9, i_b9, i_b8, i_bus};
    end else begin
      o_pair = {fall, i_ef9, i_b9, i_b8, i_bus};
      o_pairs++;
    end
  end
endmodule

/* File: testbench/testbench.sv */
module testbench import rxf_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [1:0] mode;
    logic code;
    rxf_word_t word;
  } rxf_row_t;
  logic i_clk = 0;
  logic i_rst_b = 0;
  logic i_code = 0;
  logic i_word_valid = 0;
  logic [1:0] i_mode = 2'h0;
  rxf_word_t i_word = '0;
  logic o_word_ready, o_rclk, o_b8, o_b9, o_ef9;
  logic [7:0] o_bus;
  logic [21:0] pair;
  int pairs;
  int failures = 0;
  int compares = 0;
  int n;
  rxf_row_t rows[4] = '{
    '{2'h0, 1'b0, 25'h15a5a5f}, '{2'h0, 1'b1, 25'h0c3e31c},
    '{2'h2, 1'b0, 25'h1d2b4f5}, '{2'h2, 1'b1, 25'h0a7c81e}};

  always #4 i_clk = ~i_clk;

  rxf_top i_dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_mode(i_mode), .i_code(i_code),
    .i_word_valid(i_word_valid), .o_word_ready(o_word_ready), .i_word(i_word),
    .o_rclk(o_rclk), .o_rx_gh_data_bus(o_bus), .o_rx_gh_bit8_kflag_out(o_b8),
    .o_rx_gh_bit9_out(o_b9), .o_rx_ef_bit9_out(o_ef9));
  rxf_far_end i_far (.i_rclk(o_rclk), .i_bus(o_bus), .i_b8(o_b8), .i_b9(o_b9),
    .i_ef9(o_ef9), .o_pair(pair), .o_pairs(pairs));

  task automatic check(input string name, input logic [21:0] seen, input logic [21:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // fall slot in the upper eleven bits, rise slot below: {ef9, b9, b8, bus}
  function automatic logic [21:0] expect_pair(logic [1:0] m, logic c, rxf_word_t w);
    if (m == 2'h2 && c) return {1'b0, w.h[4:0], w.g[4:0], 2'h0, w.h_k, w.h[7:5], 1'b0,
      w.g_k, w.g[7:5]};
    if (m == 2'h2) return {w.f_b4, w.h[4:0], w.g[4:0], w.f_b9, w.h[9:5],
      w.g[9:5]};
    if (c) return {2'h0, w.g_k, w.g[7:0], 2'h0, w.h_k, w.h[7:0]};
    return {w.e_b9, w.g, w.f_b9, w.h};
  endfunction

  task automatic run(input rxf_row_t r);
    int p;
    i_mode = r.mode;
    i_code = r.code;
    repeat (10) @(posedge i_clk);
    #1;
    p = pairs;
    i_word = r.word;
    i_word_valid = 1;
    n = 0;
    while (n < 40) begin
      @(posedge i_clk);
      if (o_word_ready) break;
      n++;
    end
    if (n == 40) begin
      failures++;
      results();
    end
    #1;
    i_word_valid = 0;
    // the released data lines must not keep showing the word
    i_word = ~r.word;
    n = 0;
    while (n < 40 && (pairs == p || pair === 22'h0)) begin
      @(posedge i_clk);
      n++;
    end
    // step off the edge so the next row's inputs never race the samplers
    #1;
    if (n == 40) begin
      failures++;
      results();
    end
    check("pair", pair, expect_pair(r.mode, r.code, r.word));
  endtask

  initial begin
    repeat (2) @(posedge i_clk);
    #1;
    check("reset", {10'h0, o_rclk, o_ef9, o_b9, o_b8, o_bus}, 22'h0);
    i_rst_b = 1;
    foreach (rows[i]) run(rows[i]);
    // push every cycle: drain is one word per two slots, so the buffer must fill
    i_mode = 2'h0;
    i_word = rows[0].word;
    i_word_valid = 1;
    n = 0;
    while (n < 40 && o_word_ready) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    check("ready_full", {21'h0, o_word_ready}, 22'h0);
    i_word_valid = 0;
    i_word = ~rows[0].word;
    n = 0;
    while (n < 40 && !o_word_ready) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    check("ready_drain", {21'h0, o_word_ready}, 22'h1);
    // mid-run reset: pins quiet and o_word_ready high after one edge, rising slot first after release
    i_rst_b = 0;
    @(posedge i_clk);
    #1;
    check("reset_mid", {9'h0, o_word_ready, o_rclk, o_ef9, o_b9, o_b8, o_bus}, 22'h001000);
    i_rst_b = 1;
    @(posedge i_clk);
    #1;
    check("reset_exit", {10'h0, o_rclk, o_ef9, o_b9, o_b8, o_bus}, 22'h000800);
    results();
  end
endmodule
